// [hdl/serial_shift_port.v]
`timescale 1ns/100ps
`default_nettype none
`include "shift_port_regs.vh"

module serial_shift_port (
  // Clock, reset, enable
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       ce_i,
  // Processor side
  input  wire [2:0] mode_i,
  input  wire [7:0] timer_latch_i,
  input  wire       data_wr_i,
  input  wire [7:0] data_wdata_i,
  input  wire       data_rd_i,
  output reg  [7:0] shift_data_reg_o,
  input  wire       flag_clr_i,
  output reg        shift_flag_o,
  output wire       busy_o,
  // Shift clock line, two-way
  input  wire       shift_clock_line_i,
  output reg        shift_clock_line_o,
  output wire       shift_clock_line_oe_o,
  // Shift data line, two-way
  input  wire       shift_data_line_i,
  output reg        shift_data_line_o,
  output wire       shift_data_line_oe_o
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_RUN  = 2'h1;
  // Clock stopped, last bit still in the data synchroniser
  localparam ST_TAIL = 2'h2;

  reg  [1:0] state;
  reg  [1:0] cap_pipe;
  reg  [3:0] bit_cnt;
  reg  [7:0] tmr_cnt;
  reg  [2:0] mode_q;
  reg  [7:0] shreg;
  reg        din_meta;
  reg        din_sync;
  wire       ext_rise;
  wire       ext_fall;

  function is_out;
    input [2:0] m;
    begin
      is_out = m[`MODE_DIR_BIT];
    end
  endfunction

  function [1:0] src_of;
    input [2:0] m;
    begin
      src_of = (m == `MODE_FREE_RUN) ? `SRC_TIMER : m[`MODE_SRC_HI:`MODE_SRC_LO];
    end
  endfunction

  wire       dir_out = is_out(mode_q);
  wire [1:0] src     = src_of(mode_q);
  wire       free_run = (mode_q == `MODE_FREE_RUN);
  wire       enabled  = (mode_q != `MODE_OFF);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  shift_edge_sync u_clk_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .async_i (shift_clock_line_i),
    .level_o (),
    .rise_o  (ext_rise),
    .fall_o  (ext_fall)
  );

  // Data line only read by the second stage
  always @(posedge clk_i) begin
    if (rst_i) begin
      din_meta <= 1'b0;
      din_sync <= 1'b0;
    end else if (ce_i) begin
      din_meta <= shift_data_line_i;
      din_sync <= din_meta;
    end
  end

  // ----------------------------------------
  // Internal bit clock
  // ----------------------------------------
  // timer half-period
  wire tmr_tick = (tmr_cnt == `TIMER_ZERO);
  wire int_tick = (src == `SRC_SYSCLK) ? 1'b1 : tmr_tick;
  wire int_src  = (src != `SRC_EXT);
  // Half-bit toggle: fall first, then rise
  wire int_fall = int_src & int_tick & shift_clock_line_o;
  wire int_rise = int_src & int_tick & ~shift_clock_line_o;
  wire do_fall  = (state == ST_RUN) & (int_src ? int_fall : ext_fall);
  wire do_rise  = (state == ST_RUN) & (int_src ? int_rise : ext_rise);

  wire start_rd = data_rd_i;
  wire start_wr = data_wr_i & is_out(mode_q);
  wire start    = enabled & (start_rd | start_wr);
  wire eighth   = do_rise & (bit_cnt == `BITS_PER_BYTE - 4'h1) & ~free_run;
  // Own clock in-mode: synchronised data trails the clock by two cycles
  wire in_int   = ~dir_out & int_src;
  wire cap_now  = ~dir_out & (in_int ? cap_pipe[1] : do_rise);
  wire last_bit = in_int ? ((state == ST_TAIL) & cap_pipe[1]) : eighth;

  assign busy_o = (state != ST_IDLE);
  // Sys-clock and timer sources drive the clock; external source only listens
  assign shift_clock_line_oe_o = enabled & int_src;
  assign shift_data_line_oe_o  = enabled & dir_out;

  // ----------------------------------------
  // Main sequencer
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      state              <= ST_IDLE;
      bit_cnt            <= `BIT_CNT_ZERO;
      cap_pipe           <= 2'h0;
      tmr_cnt            <= `TIMER_ZERO;
      mode_q             <= `MODE_OFF;
      shreg              <= `BYTE_ZERO;
      shift_clock_line_o <= 1'b1;
      shift_data_line_o  <= 1'b1;
      shift_flag_o       <= 1'b0;
      shift_data_reg_o   <= `BYTE_ZERO;
    end else if (ce_i) begin
      mode_q <= mode_i;
      if (mode_i != mode_q) begin
        state              <= ST_IDLE;
        bit_cnt            <= `BIT_CNT_ZERO;
        cap_pipe           <= 2'h0;
        shift_clock_line_o <= 1'b1;
      end else begin
        cap_pipe <= {cap_pipe[0], do_rise & in_int};
        case (state)
          ST_IDLE: begin
            shift_clock_line_o <= 1'b1;
            if (start) begin
              state   <= ST_RUN;
              bit_cnt <= `BIT_CNT_ZERO;
              tmr_cnt <= timer_latch_i;
            end
          end
          ST_RUN: begin
            if (int_src) begin
              tmr_cnt <= tmr_tick ? timer_latch_i : tmr_cnt - 8'h01;
            end
            if (int_src & int_tick) begin
              shift_clock_line_o <= ~shift_clock_line_o;
            end
            if (do_fall & dir_out) begin
              shift_data_line_o <= shreg[`BYTE_TOP];
            end
            if (do_rise) begin
              if (dir_out) begin
                shreg <= {shreg[`BYTE_TOP-1:`BYTE_BOTTOM], shreg[`BYTE_TOP]};
              end
              bit_cnt <= (bit_cnt == `BITS_PER_BYTE - 4'h1) ? `BIT_CNT_ZERO
                                                             : bit_cnt + 4'h1;
            end
            if (eighth) begin
              state <= in_int ? ST_TAIL : ST_IDLE;
            end
          end
          ST_TAIL: begin
            if (last_bit) begin
              state <= ST_IDLE;
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
        if (cap_now) begin
          shreg <= {shreg[`BYTE_TOP-1:`BYTE_BOTTOM], din_sync};
        end
      end
      // Processor load wins over shifting in the same cycle
      if (data_wr_i) begin
        shreg <= data_wdata_i;
      end
      shift_data_reg_o <= shreg;
      if (last_bit) begin
        shift_flag_o <= 1'b1;
      end else if (flag_clr_i & shift_flag_o) begin
        shift_flag_o <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// [hdl/shift_port_regs.vh]
`ifndef SHIFT_PORT_REGS_VH
`define SHIFT_PORT_REGS_VH

// ----------------------------------------
// Mode field codes
// ----------------------------------------
`define MODE_OFF       3'h0
`define MODE_IN_TMR    3'h1
`define MODE_IN_SYS    3'h2
`define MODE_IN_EXT    3'h3
`define MODE_FREE_RUN  3'h4
`define MODE_OUT_TMR   3'h5
`define MODE_OUT_SYS   3'h6
`define MODE_OUT_EXT   3'h7

// ----------------------------------------
// Field positions and values
// ----------------------------------------
`define MODE_DIR_BIT   2
`define MODE_SRC_HI    1
`define MODE_SRC_LO    0
`define SRC_TIMER      2'h1
`define SRC_SYSCLK     2'h2
`define SRC_EXT        2'h3
`define BITS_PER_BYTE  4'h8
`define BIT_CNT_ZERO   4'h0
`define BYTE_ZERO      8'h00
`define TIMER_ZERO     8'h00
`define BYTE_TOP       7
`define BYTE_BOTTOM    0

`endif

// [hdl/shift_edge_sync.v]
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// Two-stage synchroniser with edge pulses
// ----------------------------------------
module shift_edge_sync (
  // Clock and control
  input  wire clk_i,
  input  wire rst_i,
  input  wire ce_i,
  // Async level
  input  wire async_i,
  // Synchronised level and edges
  output reg  level_o,
  output wire rise_o,
  output wire fall_o
);

  reg meta;
  reg prev;

  // Reset high: idle shift clock sits high
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta    <= 1'b1;
      level_o <= 1'b1;
      prev    <= 1'b1;
    end else if (ce_i) begin
      meta    <= async_i;
      level_o <= meta;
      prev    <= level_o;
    end
  end

  assign rise_o = ce_i & level_o & ~prev;
  assign fall_o = ce_i & ~level_o & prev;

endmodule

`default_nettype wire

// [dv/serial_shift_port_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
module serial_shift_port_assertions (
  input wire logic       clk_i, rst_i, data_wr_i, data_rd_i, flag_clr_i, busy_o, shift_flag_o,
  input wire logic       shift_clock_line_o, shift_data_line_o, shift_data_line_oe_o,
  input wire logic [2:0] mode_i
);
  logic [2:0] m1, m2;
  logic [3:0] falls;
  logic       pc;
  // Mode held three samples, so the lagging mode register agrees
  wire logic  calm = mode_i == m1 && m1 == m2;
  always @(posedge clk_i) begin
    m1 <= mode_i;
    m2 <= m1;
    pc <= shift_clock_line_o;
    // Falls, since in out-modes the eighth rise drops busy at once
    falls <= busy_o ? falls + {3'h0, ~shift_clock_line_o & pc} : 4'h0;
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_rst; $fell(rst_i) |-> !shift_flag_o && !busy_o && shift_clock_line_o; endproperty
  a_rst: assert property (p_rst) else $error("not idle");
  property p_rd; !busy_o && !$past(busy_o) && data_rd_i && mode_i != 3'h0 && calm |=> busy_o;
  endproperty
  a_rd: assert property (p_rd) else $error("no read start");
  property p_wr; !busy_o && !$past(busy_o) && data_wr_i && mode_i[2] && calm |=> busy_o; endproperty
  a_wr: assert property (p_wr) else $error("no write start");
  property p_flag; $fell(busy_o) && calm |-> shift_flag_o; endproperty
  a_flag: assert property (p_flag) else $error("no flag");
  property p_eight; $fell(busy_o) && calm && mode_i[1:0] != 2'h3 |-> falls == 4'h8; endproperty
  a_eight: assert property (p_eight) else $error("not eight");
  property p_fall; busy_o && $past(busy_o) && mode_i[2] && mode_i[1:0] != 2'h3
    && $changed(shift_data_line_o) |-> !shift_clock_line_o || !$past(shift_clock_line_o);
  endproperty
  a_fall: assert property (p_fall) else $error("data moved");
  property p_clr; shift_flag_o && flag_clr_i && !busy_o |=> !shift_flag_o; endproperty
  a_clr: assert property (p_clr) else $error("flag kept");
  property p_oe; !$past(rst_i) && $stable(mode_i) |-> shift_data_line_oe_o == mode_i[2]; endproperty
  a_oe: assert property (p_oe) else $error("bad enable");
endmodule
bind serial_shift_port serial_shift_port_assertions u_check (.*);
`default_nettype wire

// [dv/shift_partner.sv]
`timescale 1ns/100ps
`default_nettype none
module shift_partner (
  input  wire logic       sck_i, sd_i, go_i, ext_i,
  input  wire logic [7:0] tx_i,
  output var  logic       sck_o, sd_o,
  output var  logic [7:0] rx_o
);
  logic [7:0] txs;
  initial {sck_o, sd_o, rx_o, txs} = 18'h3_0000;
  // Clock stands high between frames
  always @(posedge go_i) begin
    txs = tx_i;
    sd_o = tx_i[7];
    if (ext_i)
      repeat (8) begin
        #80 sck_o = 1'b0;
        #80 sck_o = 1'b1;
      end
  end
  always @(negedge sck_i) begin
    sd_o = txs[7];
    txs = {txs[6:0], ~txs[7]};
  end
  // Small delay: in system-clock mode the bit lands on the falling edge, one cycle before the rise
  always @(posedge sck_i) begin
    #1;
    rx_o = {rx_o[6:0], sd_i};
  end
endmodule
`default_nettype wire

// [dv/tb_serial_shift_port.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_serial_shift_port;
  logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, data_wr_i = 1'b0, data_rd_i = 1'b0;
  logic flag_clr_i = 1'b0, go = 1'b0, ext = 1'b0, shift_flag_o, busy_o, psck, psd;
  logic shift_clock_line_o, shift_clock_line_oe_o, shift_data_line_o, shift_data_line_oe_o;
  logic [2:0] mode_i = 3'h0;
  logic [7:0] timer_latch_i = 8'h02, data_wdata_i = 8'h00, shift_data_reg_o, tx, rx;
  logic [31:0] seed = 32'h0000_0032;
  int mismatches = 0, total_checks = 0, k;
  wire logic shift_clock_line_i = shift_clock_line_oe_o ? shift_clock_line_o : psck;
  wire logic shift_data_line_i = shift_data_line_oe_o ? shift_data_line_o : psd;
  serial_shift_port dut (.*);
  shift_partner far_end (.sck_i(shift_clock_line_i), .sd_i(shift_data_line_i), .go_i(go),
    .ext_i(ext), .tx_i(tx), .sck_o(psck), .sd_o(psd), .rx_o(rx));
  initial forever #10 clk_i = ~clk_i;
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic setm(input logic [2:0] m);
    @(negedge clk_i);
    mode_i = m;
    ext = m[1:0] == 2'h3;
    repeat (2) @(negedge clk_i);
  endtask
  // Bits: write, read, flag clear
  task automatic pulse(input logic [2:0] p);
    @(negedge clk_i);
    {data_wr_i, data_rd_i, flag_clr_i, go} = {p, p[2] | p[1]};
    @(negedge clk_i);
    {data_wr_i, data_rd_i, flag_clr_i, go} = 4'h0;
  endtask
  task automatic done();
    for (k = 0; k < 3000 && busy_o !== 1'b0; k++) @(negedge clk_i);
    if (k == 3000) mismatches++;
    @(negedge clk_i);
  endtask
  initial begin
    #200000;
    mismatches++;
    stop_test();
  end
  initial begin
    repeat (4) @(negedge clk_i);
    rst_i = 1'b0;
    @(negedge clk_i);
    chk({5'h00, shift_flag_o, busy_o, shift_clock_line_o}, 8'h01);
    for (int m = 5; m < 8; m++) begin
      tx = rnd();
      data_wdata_i = tx;
      timer_latch_i = 8'h02 + (rnd() & 8'h07);
      setm(m[2:0]);
      pulse(3'h4);
      done();
      chk(rx, tx);
      chk({7'h00, shift_flag_o}, 8'h01);
      chk({6'h00, shift_clock_line_oe_o, shift_data_line_oe_o},
          {6'h00, m != 7, 1'b1});
      chk(shift_data_reg_o, tx);
      pulse(3'h1);
      chk({7'h00, shift_flag_o}, 8'h00);
      pulse(3'h2);
      done();
      chk(rx, tx);
    end
    for (int m = 1; m < 4; m++) begin
      tx = rnd();
      timer_latch_i = 8'h02 + (rnd() & 8'h07);
      setm(m[2:0]);
      pulse(3'h2);
      done();
      chk(shift_data_reg_o, tx);
      chk({6'h00, shift_clock_line_oe_o, shift_data_line_oe_o},
          {6'h00, m != 3, 1'b0});
    end
    tx = 8'he0;
    data_wdata_i = tx;
    timer_latch_i = 8'h01;
    setm(3'h4);
    pulse(3'h4);
    repeat (200) @(negedge clk_i);
    chk({7'h00, busy_o}, 8'h01);
    chk(8'($countones(rx)), 8'h03);
    setm(3'h0);
    pulse(3'h6);
    chk({4'h0, busy_o, shift_clock_line_o, shift_clock_line_oe_o, shift_data_line_oe_o},
        8'h04);
    stop_test();
  end
endmodule
`default_nettype wire
